// ### design/bcc_burst_clock_counter.sv
`include "bcc_defs.svh"

module bcc_burst_clock_counter #(
    parameter logic [`BCC_COUNT_WIDTH-1:0] COUNT_MASK = `BCC_MASK_FULL
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_condition_input,
    input  wire bcc_pkg::bcc_count_type i_count_value,
    input  wire logic                  i_direct_mode,
    input  wire logic                  i_count_enable_n,
    output logic                       o_burst_gate_out,
    output logic                       o_equality_flag,
    output bcc_pkg::bcc_count_type     o_count
);
    import bcc_pkg::*;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic          load_meta;
    logic          load_sync;
    logic          dir_meta;
    logic          dir_sync;
    logic          en_n_meta;
    logic          en_n_sync;
    bcc_count_type cnt_meta;
    bcc_count_type cnt_sync;
    // sequencer state, the live counter and the mode taken at load
    bcc_state_type state;
    bcc_state_type next_state;
    bcc_count_type counter;
    logic          direct;

    // ************************************************************
    // shared decodes
    // ************************************************************
    // zero test used by the sequencer and the down-counter alike, so both
    // agree on the very same clock at which the burst ends
    function automatic logic bcc_is_zero(input bcc_count_type value);
        return value == `BCC_COUNT_RESET;
    endfunction : bcc_is_zero

    // states in which clock pulses may pass; every other state keeps the
    // gate high, so an unknown or unused state can never open it
    function automatic logic bcc_gate_low(input bcc_state_type value);
        return value == BCC_COUNT || value == BCC_LOW;
    endfunction : bcc_gate_low

    // load request pin, two stages; resets high so no burst starts early
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            load_meta <= 1'b1;
            load_sync <= 1'b1;
        end else begin
            load_meta <= i_condition_input;
            load_sync <= load_meta;
        end
    end

    // mode pin, two stages; only read while the load is being accepted
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            dir_meta <= 1'b0;
            dir_sync <= 1'b0;
        end else begin
            dir_meta <= i_direct_mode;
            dir_sync <= dir_meta;
        end
    end

    // enable pin, two stages; a change mid-burst takes effect two clocks
    // later, which the host must allow for when it pauses a burst
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            en_n_meta <= 1'b1;
            en_n_sync <= 1'b1;
        end else begin
            en_n_meta <= i_count_enable_n;
            en_n_sync <= en_n_meta;
        end
    end

    // count pins, two stages per bit; not gray coded, so the host must hold
    // the count steady from before the load falls until the gate falls
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_meta <= `BCC_COUNT_RESET;
            cnt_sync <= `BCC_COUNT_RESET;
        end else begin
            cnt_meta <= i_count_value;
            cnt_sync <= cnt_meta;
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    // counting stalls in place while the enable is high
    // a load held low past the burst starts the next one after three high
    // clocks; the host must release it early to get a single burst
    // in direct mode the enable is honoured only in the high phase
    always_comb begin
        next_state = state;
        case (state)
            BCC_IDLE: begin
                if (!load_sync) begin
                    next_state = BCC_LOAD;
                end
            end
            BCC_LOAD: begin
                next_state = direct ? BCC_HIGH : BCC_COUNT;
            end
            BCC_COUNT: begin
                if (!en_n_sync && bcc_is_zero(counter)) begin
                    next_state = BCC_RETURN;
                end
            end
            BCC_HIGH: begin
                if (!en_n_sync) begin
                    next_state = BCC_LOW;
                end
            end
            BCC_LOW: begin
                if (bcc_is_zero(counter)) begin
                    next_state = BCC_RETURN;
                end else begin
                    next_state = BCC_HIGH;
                end
            end
            BCC_RETURN: begin
                next_state = BCC_IDLE;
            end
            default: begin
                next_state = BCC_IDLE;
            end
        endcase
    end

    // state register; reset lands in idle with the gate high
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= BCC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // mode is latched at load so a mid-burst change cannot garble it
    // it resets to gated mode, which keeps the gate high until a load
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            direct <= 1'b0;
        end else if (state == BCC_IDLE && !load_sync) begin
            direct <= dir_sync;
        end
    end

    // ************************************************************
    // down-counter
    // ************************************************************
    // loads once per burst; the flag test keeps the conditional load form
    // and always passes because nothing in this block ever sets the flag
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            counter <= `BCC_COUNT_RESET;
        end else if (state == BCC_LOAD && !o_equality_flag) begin
            counter <= cnt_sync & COUNT_MASK;
        end else if (state == BCC_COUNT && !en_n_sync && !bcc_is_zero(counter)) begin
            counter <= counter - 6'h01;
        end else if (state == BCC_LOW && !bcc_is_zero(counter)) begin
            counter <= counter - 6'h01;
        end
    end

    // equality flag: never set by this program, cleared by reset and again on every clock
    // kept as a register so the port still comes straight from a flop
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_equality_flag <= 1'b0;
        end else begin
            o_equality_flag <= 1'b0;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // gate is registered from the next state: falls one clock after load leaves idle in gated mode, two clocks after in direct mode
    // decoding next_state rather than state saves a clock of latency
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_burst_gate_out <= 1'b1;
        end else begin
            // with the enable low, count state is counter+1 clocks long, giving counter+1 gated pulses
            o_burst_gate_out <= !bcc_gate_low(next_state);
        end
    end

    // counter mirror for observation, one clock behind the live value
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_count <= `BCC_COUNT_RESET;
        end else begin
            o_count <= counter;
        end
    end

    // gated mode relies on outside logic forming clk AND NOT gate
    // the gate changes just after the rising edge, so that AND sees it
    // settled while the clock is high only if the gate path is kept short

endmodule : bcc_burst_clock_counter

// ### design/bcc_defs.svh
`ifndef BCC_DEFS_SVH
`define BCC_DEFS_SVH

// ************************************************************
// widths and masks
// ************************************************************
`define BCC_COUNT_WIDTH   6
`define BCC_MASK_FULL     6'h3F
`define BCC_MASK_LOW4     6'h0F
`define BCC_COUNT_RESET   6'h00

// ************************************************************
// rates
// ************************************************************
`define BCC_CLK_MHZ         20
`define BCC_DIRECT_MAX_MHZ  10
`define BCC_GATED_MAX_MHZ   20

`endif

// ### design/bcc_pkg.sv
`include "bcc_defs.svh"

package bcc_pkg;

    // ************************************************************
    // sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        BCC_IDLE,
        BCC_LOAD,
        BCC_COUNT,
        BCC_HIGH,
        BCC_LOW,
        BCC_RETURN
    } bcc_state_type;

    typedef logic [`BCC_COUNT_WIDTH-1:0] bcc_count_type;

endpackage : bcc_pkg

// ### verification/bcc_burst_clock_counter_asserts.sv
// ****
// burst counter port checker
// ****
module bcc_asserts (
    input wire logic                   i_clk,
    input wire logic                   i_reset,
    input wire logic                   i_condition_input,
    input wire bcc_pkg::bcc_count_type i_count_value,
    input wire logic                   i_direct_mode,
    input wire logic                   i_count_enable_n,
    input wire logic                   o_burst_gate_out,
    input wire logic                   o_equality_flag,
    input wire bcc_pkg::bcc_count_type o_count
);
    timeunit 1ns;
    timeprecision 1ns;
    import bcc_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // fresh request seen while idle, gate high for two samples
    sequence load_seen;
        $fell(i_condition_input) && o_burst_gate_out && $past(o_burst_gate_out);
    endsequence
    chk_reset_idle: assert property ($fell(i_reset) |-> o_burst_gate_out && o_count == 6'h00)
        else $error("gate or count wrong after reset");
    chk_flag_clear: assert property (!o_equality_flag)
        else $error("equality flag set");
    chk_idle_gate_high: assert property ((i_condition_input && o_burst_gate_out)[*4] |=> o_burst_gate_out)
        else $error("gate left idle without request");
    chk_load_gate_high: assert property (load_seen |=> o_burst_gate_out[*2])
        else $error("gate fell during load step");
    // two sync stages, one idle-to-load clock, then one load clock: pin low four samples back
    chk_gate_fall_delay: assert property (
        $fell(o_burst_gate_out) && $past(o_burst_gate_out, 2) |-> !$past(i_condition_input, 4))
        else $error("gate fell without prior request");
    chk_return_idle: assert property ($rose(o_burst_gate_out) && !i_direct_mode |=> o_burst_gate_out)
        else $error("gate not held high after burst");
    chk_direct_toggle: assert property ($fell(o_burst_gate_out) && i_direct_mode |=> o_burst_gate_out)
        else $error("direct low phase longer than one clock");
    chk_stall_hold: assert property (
        (!o_burst_gate_out && i_count_enable_n && !i_direct_mode)[*4] |=> !o_burst_gate_out)
        else $error("burst ended while count disabled");
endmodule : bcc_asserts

// ### verification/bcc_host_model.sv
// ****
// host side: counts gated clock pulses
// ****
module bcc_host_model (
    input  wire logic       i_clk,
    input  wire logic       i_clear,
    input  wire logic       i_burst_gate_out,
    output logic [6:0]      o_pulses,
    output logic [6:0]      o_phases
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_gate;
    // clock passes while gate is low; sampled on edges to avoid gating glitches
    always_ff @(posedge i_clk) begin
        last_gate <= i_burst_gate_out;
        if (i_clear) begin
            o_pulses <= 7'h00;
            o_phases <= 7'h00;
        end else begin
            if (!i_burst_gate_out) o_pulses <= o_pulses + 7'h01;
            if (last_gate && !i_burst_gate_out) o_phases <= o_phases + 7'h01;
        end
    end
endmodule : bcc_host_model

// ### verification/testbench.sv
// ****
// burst counter bench
// ****
`include "bcc_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import bcc_pkg::*;
    logic          i_clk, i_reset, i_condition_input, i_direct_mode, i_count_enable_n, clear;
    logic          o_burst_gate_out, o_equality_flag;
    bcc_count_type i_count_value, o_count;
    logic [6:0]    pulses, phases;
    logic [6:0]    pulses_narrow;
    logic          gate_narrow;
    bcc_count_type count_narrow;
    int            n_errors = 0;
    int            num_checks = 0;
    bcc_burst_clock_counter dut (.i_clk(i_clk), .i_reset(i_reset), .i_condition_input(i_condition_input),
        .i_count_value(i_count_value), .i_direct_mode(i_direct_mode), .i_count_enable_n(i_count_enable_n),
        .o_burst_gate_out(o_burst_gate_out), .o_equality_flag(o_equality_flag), .o_count(o_count));
    bcc_host_model host (.i_clk(i_clk), .i_clear(clear), .i_burst_gate_out(o_burst_gate_out),
        .o_pulses(pulses), .o_phases(phases));
    // second unit with the four-bit mask, fed the same stimulus
    bcc_burst_clock_counter #(.COUNT_MASK(`BCC_MASK_LOW4)) dut_narrow (.i_clk(i_clk), .i_reset(i_reset),
        .i_condition_input(i_condition_input), .i_count_value(i_count_value), .i_direct_mode(i_direct_mode),
        .i_count_enable_n(i_count_enable_n), .o_burst_gate_out(gate_narrow), .o_equality_flag(),
        .o_count(count_narrow));
    bcc_host_model host_narrow (.i_clk(i_clk), .i_clear(clear), .i_burst_gate_out(gate_narrow),
        .o_pulses(pulses_narrow), .o_phases());
    // 50 ns period
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic check(input logic [6:0] got, input logic [6:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task complete_run;
        if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // one burst; a stall holds the enable off just after the gate falls
    task automatic run_burst(input logic [5:0] v, input logic dm, input int stall);
        int k;
        int hi;
        clear = 1'b1;
        @(negedge i_clk);
        clear = 1'b0;
        {i_count_value, i_direct_mode, i_condition_input} = {v, dm, 1'b0};
        // request held until the gate answers, bounded
        for (k = 0; k < 20 && o_burst_gate_out !== 1'b0; k++) @(negedge i_clk);
        if (o_burst_gate_out !== 1'b0) begin
            n_errors++;
            complete_run();
        end
        {i_condition_input, i_count_enable_n} = {1'b1, stall > 0};
        repeat (stall) @(negedge i_clk);
        i_count_enable_n = 1'b0;
        hi = 0;
        for (k = 0; k < 200 && hi < 3; k++) begin
            @(negedge i_clk);
            hi = (o_burst_gate_out === 1'b1) ? hi + 1 : 0;
        end
        if (hi < 3) begin
            n_errors++;
            complete_run();
        end
        // each stalled clock keeps the gate low and so passes one more pulse
        check(pulses, {1'b0, v} + 7'h01 + 7'(stall));
        check(pulses_narrow, {1'b0, v & `BCC_MASK_LOW4} + 7'h01 + 7'(stall));
        check({1'b0, o_count}, 7'h00);
        check({1'b0, count_narrow}, 7'h00);
        if (dm) check(phases, {1'b0, v} + 7'h01);
    endtask : run_burst
    // reset, then bursts at the count boundaries and in both modes
    initial begin
        {i_reset, i_condition_input, i_direct_mode, i_count_enable_n, clear, i_count_value} = {5'b11000, 6'h00};
        repeat (12) @(negedge i_clk);
        i_reset = 1'b0;
        @(negedge i_clk);
        check({o_burst_gate_out, o_count}, 7'h40);
        check({6'h00, o_equality_flag}, 7'h00);
        run_burst(6'h00, 1'b0, 0);
        run_burst(6'h3F, 1'b0, 0);
        run_burst(6'h01, 1'b0, 0);
        run_burst(6'h05, 1'b0, 6);
        run_burst(6'h02, 1'b1, 0);
        run_burst(6'h00, 1'b1, 0);
        complete_run();
    end
endmodule : testbench
bind bcc_burst_clock_counter bcc_asserts u_chk (.i_clk(i_clk), .i_reset(i_reset),
    .i_condition_input(i_condition_input), .i_count_value(i_count_value), .i_direct_mode(i_direct_mode),
    .i_count_enable_n(i_count_enable_n), .o_burst_gate_out(o_burst_gate_out),
    .o_equality_flag(o_equality_flag), .o_count(o_count));
